// ===== core/cpu_bus_ctrl.sv
// Bus-cycle timing generator and reset sequencer with Wishbone registers
`timescale 1ns/100ps
module cpu_bus_ctrl #(
	parameter int STATE_DIV = 1,
	parameter bit EXT_MODEL = 1'b1
) (
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic SYSTEM_RESET_N,
	input wire logic STRETCH_N,
	input wire logic [7:0] DATA_IN,
	output logic [7:0] DATA_OUT,
	output logic DATA_OE,
	output logic [23:0] ADDR,
	output logic BUS_OE,
	output logic READ_STROBE_N,
	output logic WRITE_STROBE_N,
	output logic VECTOR_READ_STROBE_N,
	output logic BUS_STATUS_BIT_HI,
	output logic BUS_STATUS_BIT_LO,
	output logic INTERRUPT_ACKNOWLEDGE,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [cpu_bus_pkg::WB_ADR_W-1:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [3:0] WB_SEL_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Byte-lane merge of a bus write into an old word
	function automatic logic [31:0] merge(logic [31:0] old,
		logic [31:0] wd, logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Open a new bus cycle in T1
	function automatic cpu_bus_pkg::state_t start(cpu_bus_pkg::state_t x,
		cpu_bus_pkg::bus_kind_t k, logic [23:0] a, logic [7:0] d);
		cpu_bus_pkg::state_t r;
		r = x;
		r.phase = cpu_bus_pkg::PH_T1;
		r.kind = k;
		r.addr = a;
		r.wdata = d;
		return r;
	endfunction

	cpu_bus_pkg::state_t st_reg;
	cpu_bus_pkg::state_t st_next;
	logic state_en;
	logic wb_req;
	logic wb_wr;
	logic cycle_end;
	logic idle_or_end;
	logic in_strobe;
	logic [31:0] wr_word;
	logic [31:0] rd_word;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		rd_word = '0;
		wr_word = '0;
		// State divider: one enable per half CPU clock
		state_en = (st_reg.div == 8'(STATE_DIV - 1)); // R01
		st_next.div = state_en ? 8'h00 : st_reg.div + 8'h01;
		if (state_en) begin
			st_next.clk_ph = ~st_reg.clk_ph; // R01
		end
		cycle_end = state_en && (st_reg.phase == cpu_bus_pkg::PH_T4);
		idle_or_end = cycle_end ||
			(state_en && (st_reg.phase == cpu_bus_pkg::PH_IDLE));

		// Phase sequencer of the bus cycle
		if (state_en) begin
			case (st_reg.phase)
				cpu_bus_pkg::PH_T1: begin
					st_next.phase = cpu_bus_pkg::PH_T2; // R20
				end
				cpu_bus_pkg::PH_T2: begin
					st_next.phase = cpu_bus_pkg::PH_T3; // R20
				end
				cpu_bus_pkg::PH_T3: begin
					// Stretch sampled at the end of T3, every cycle kind but internal
					if (st_reg.kind != cpu_bus_pkg::BS_IDLE && !STRETCH_N) begin
						st_next.phase = cpu_bus_pkg::PH_TW1; // R07 R09
					end else begin
						st_next.phase = cpu_bus_pkg::PH_T4; // R07 R20
						st_next.rdata = DATA_IN; // R06 R04
					end
				end
				cpu_bus_pkg::PH_TW1: begin
					st_next.phase = cpu_bus_pkg::PH_TW2; // R08
				end
				cpu_bus_pkg::PH_TW2: begin
					// Resample; keep stretching in pairs while low
					if (!STRETCH_N) begin
						st_next.phase = cpu_bus_pkg::PH_TW1; // R08
					end else begin
						st_next.phase = cpu_bus_pkg::PH_T4; // R08
						st_next.rdata = DATA_IN; // R06 R04
					end
				end
				default: begin
					st_next.phase = cpu_bus_pkg::PH_IDLE;
					st_next.kind = cpu_bus_pkg::BS_IDLE;
				end
			endcase
		end

		// Processing state and reset sequence
		case (st_reg.proc)
			cpu_bus_pkg::PS_RESET: begin
				// Count CPU clock falls, then open a dummy cycle
				if (state_en && st_reg.clk_ph) begin
					st_next.falls = st_reg.falls + 2'h1;
				end
				if (idle_or_end && st_reg.falls == cpu_bus_pkg::FALLS_BEFORE_FIRST)
				begin
					st_next = start(st_next, cpu_bus_pkg::BS_IDLE,
						cpu_bus_pkg::DUMMY_ADDR, 8'h00); // R14
					st_next.proc = cpu_bus_pkg::PS_EXCEPTION; // R11
					st_next.rstep = 2'h0;
				end
			end
			cpu_bus_pkg::PS_EXCEPTION: begin
				if (cycle_end) begin
					case (st_reg.rstep)
						2'h0: begin
							st_next = start(st_next, cpu_bus_pkg::BS_READ,
								cpu_bus_pkg::RESET_VECTOR, 8'h00); // R15
							st_next.rstep = 2'h1;
						end
						2'h1: begin
							st_next.pc[7:0] = st_reg.rdata; // R15
							st_next = start(st_next, cpu_bus_pkg::BS_READ,
								cpu_bus_pkg::RESET_VECTOR + 24'h000001, 8'h00);
							st_next.rstep = 2'h2;
						end
						default: begin
							st_next.pc[15:8] = st_reg.rdata; // R15
							if (EXT_MODEL) begin
								st_next.cb = st_reg.nb; // R15 R18
							end
							st_next.proc = cpu_bus_pkg::PS_EXECUTE;
						end
					endcase
				end
			end
			cpu_bus_pkg::PS_EXECUTE: begin
				// Software-issued cycles, or leave for standby/release
				if (idle_or_end && st_reg.cmd_pend) begin
					st_next = start(st_next, st_reg.cmd_kind,
						(st_reg.cmd_kind == cpu_bus_pkg::BS_READ ||
						st_reg.cmd_kind == cpu_bus_pkg::BS_WRITE) ?
						st_reg.cmd_addr : cpu_bus_pkg::DUMMY_ADDR,
						st_reg.cmd_data); // R03 R04 R05 R06
					st_next.cmd_pend = 1'b0;
				end else if (idle_or_end) begin
					case (st_reg.mode_req)
						2'h1: st_next.proc = cpu_bus_pkg::PS_HALT; // R11
						2'h2: st_next.proc = cpu_bus_pkg::PS_SLEEP; // R11
						2'h3: st_next.proc = cpu_bus_pkg::PS_RELEASE; // R11
						default: st_next.proc = cpu_bus_pkg::PS_EXECUTE;
					endcase
				end
			end
			default: begin
				// Halt, sleep and release end when the request is cleared
				if (st_reg.mode_req == 2'h0) begin
					st_next.proc = cpu_bus_pkg::PS_EXECUTE; // R11
				end
			end
		endcase

		// Wishbone slave: one-cycle ack, write takes effect with the ack
		wb_req = WB_CYC_I && WB_STB_I;
		wb_wr = wb_req && WB_WE_I && st_reg.wb_ack;
		st_next.wb_ack = wb_req && !st_reg.wb_ack;
		case (WB_ADR_I)
			cpu_bus_pkg::OFS_MODE: rd_word = {30'h0, st_reg.mode_req};
			cpu_bus_pkg::OFS_CMD_ADDR: rd_word = {8'h00, st_reg.cmd_addr};
			cpu_bus_pkg::OFS_CMD_DATA: rd_word = {24'h0, st_reg.cmd_data};
			cpu_bus_pkg::OFS_CMD: rd_word = {30'h0, st_reg.cmd_kind};
			cpu_bus_pkg::OFS_STATUS: begin
				rd_word[cpu_bus_pkg::STAT_PROC_LSB +: 3] = st_reg.proc;
				rd_word[cpu_bus_pkg::STAT_BUSY] =
					(st_reg.phase != cpu_bus_pkg::PH_IDLE);
				rd_word[cpu_bus_pkg::STAT_PEND] = st_reg.cmd_pend;
				rd_word[cpu_bus_pkg::STAT_DATA_LSB +: 8] = st_reg.rdata;
			end
			cpu_bus_pkg::OFS_FLAGS: rd_word = {24'h0, st_reg.flags};
			cpu_bus_pkg::OFS_PC: rd_word = {16'h0, st_reg.pc};
			cpu_bus_pkg::OFS_NB: rd_word = EXT_MODEL ? {24'h0, st_reg.nb} : '0;
			cpu_bus_pkg::OFS_CB: rd_word = EXT_MODEL ? {24'h0, st_reg.cb} : '0;
			cpu_bus_pkg::OFS_EP: rd_word = EXT_MODEL ? {24'h0, st_reg.ep} : '0;
			cpu_bus_pkg::OFS_XP: rd_word = EXT_MODEL ? {24'h0, st_reg.xp} : '0;
			cpu_bus_pkg::OFS_YP: rd_word = EXT_MODEL ? {24'h0, st_reg.yp} : '0;
			default: rd_word = '0;
		endcase
		if (wb_req && !st_reg.wb_ack) begin
			st_next.wb_dat = rd_word;
		end
		// Writes are held off in reset so reset values stay intact
		if (wb_wr && st_reg.proc != cpu_bus_pkg::PS_RESET) begin
			case (WB_ADR_I)
				cpu_bus_pkg::OFS_MODE: begin
					wr_word = merge({30'h0, st_reg.mode_req}, WB_DAT_I, WB_SEL_I);
					st_next.mode_req = wr_word[1:0];
				end
				cpu_bus_pkg::OFS_CMD_ADDR: begin
					wr_word = merge({8'h00, st_reg.cmd_addr}, WB_DAT_I, WB_SEL_I);
					st_next.cmd_addr = wr_word[23:0];
				end
				cpu_bus_pkg::OFS_CMD_DATA: begin
					wr_word = merge({24'h0, st_reg.cmd_data}, WB_DAT_I, WB_SEL_I);
					st_next.cmd_data = wr_word[7:0];
				end
				cpu_bus_pkg::OFS_CMD: begin
					// Set after the launch clear above, so a new order wins
					if (WB_SEL_I[0]) begin
						st_next.cmd_kind = cpu_bus_pkg::bus_kind_t'(WB_DAT_I[1:0]);
						st_next.cmd_pend = 1'b1;
					end
				end
				cpu_bus_pkg::OFS_FLAGS: begin
					wr_word = merge({24'h0, st_reg.flags}, WB_DAT_I, WB_SEL_I);
					st_next.flags = wr_word[7:0];
				end
				cpu_bus_pkg::OFS_PC: begin
					wr_word = merge({16'h0, st_reg.pc}, WB_DAT_I, WB_SEL_I);
					st_next.pc = wr_word[15:0];
				end
				cpu_bus_pkg::OFS_NB: begin
					wr_word = merge({24'h0, st_reg.nb}, WB_DAT_I, WB_SEL_I);
					st_next.nb = EXT_MODEL ? wr_word[7:0] : st_reg.nb; // R18
				end
				cpu_bus_pkg::OFS_CB: begin
					wr_word = merge({24'h0, st_reg.cb}, WB_DAT_I, WB_SEL_I);
					st_next.cb = EXT_MODEL ? wr_word[7:0] : st_reg.cb; // R18
				end
				cpu_bus_pkg::OFS_EP: begin
					wr_word = merge({24'h0, st_reg.ep}, WB_DAT_I, WB_SEL_I);
					st_next.ep = EXT_MODEL ? wr_word[7:0] : st_reg.ep; // R18
				end
				cpu_bus_pkg::OFS_XP: begin
					wr_word = merge({24'h0, st_reg.xp}, WB_DAT_I, WB_SEL_I);
					st_next.xp = EXT_MODEL ? wr_word[7:0] : st_reg.xp; // R18
				end
				cpu_bus_pkg::OFS_YP: begin
					wr_word = merge({24'h0, st_reg.yp}, WB_DAT_I, WB_SEL_I);
					st_next.yp = EXT_MODEL ? wr_word[7:0] : st_reg.yp; // R18
				end
				default: wr_word = '0;
			endcase
		end

		// Pin levels decoded from the coming phase, so pins are registered
		in_strobe = (st_next.phase == cpu_bus_pkg::PH_T2) ||
			(st_next.phase == cpu_bus_pkg::PH_T3) ||
			(st_next.phase == cpu_bus_pkg::PH_TW1) ||
			(st_next.phase == cpu_bus_pkg::PH_TW2);
		st_next.status = (st_next.phase == cpu_bus_pkg::PH_IDLE) ?
			cpu_bus_pkg::BS_IDLE : st_next.kind; // R02
		st_next.rd_n = !(in_strobe &&
			st_next.kind == cpu_bus_pkg::BS_READ); // R06 R03
		st_next.vrd_n = !(in_strobe &&
			st_next.kind == cpu_bus_pkg::BS_VECTOR); // R04
		st_next.wr_n = !(in_strobe && st_next.phase != cpu_bus_pkg::PH_T2 &&
			st_next.kind == cpu_bus_pkg::BS_WRITE); // R05 R03
		st_next.dat_oe = st_next.kind == cpu_bus_pkg::BS_WRITE &&
			(in_strobe || st_next.phase == cpu_bus_pkg::PH_T4); // R05 R03
		st_next.bus_oe = (st_next.phase != cpu_bus_pkg::PH_IDLE) ||
			(st_next.proc != cpu_bus_pkg::PS_RESET &&
			st_next.proc != cpu_bus_pkg::PS_RELEASE); // R13
		st_next.interrupt_acknowledge = st_next.proc == cpu_bus_pkg::PS_EXCEPTION &&
			st_next.rstep == 2'h1 &&
			st_next.phase != cpu_bus_pkg::PH_IDLE; // R14
	end

	// ----------------------------------------------------------------
	// State register; system reset acts at once, bus reset on the clock
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge SYSTEM_RESET_N) begin
		if (!SYSTEM_RESET_N) begin
			st_reg <= cpu_bus_pkg::ST_INIT; // R12 R16 R17
		end else if (!NRST) begin
			st_reg <= cpu_bus_pkg::ST_INIT;
		end else begin
			st_reg <= st_next;
		end
	end

	// Ports straight from the state register
	assign DATA_OUT = st_reg.wdata;
	assign DATA_OE = st_reg.dat_oe;
	assign ADDR = st_reg.addr;
	assign BUS_OE = st_reg.bus_oe;
	assign READ_STROBE_N = st_reg.rd_n;
	assign WRITE_STROBE_N = st_reg.wr_n;
	assign VECTOR_READ_STROBE_N = st_reg.vrd_n;
	assign BUS_STATUS_BIT_HI = st_reg.status[1];
	assign BUS_STATUS_BIT_LO = st_reg.status[0];
	assign INTERRUPT_ACKNOWLEDGE = st_reg.interrupt_acknowledge;
	assign WB_DAT_O = st_reg.wb_dat;
	assign WB_ACK_O = st_reg.wb_ack;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_order;
		@(posedge MCLK) disable iff (!NRST || !SYSTEM_RESET_N)
		(st_reg.phase == cpu_bus_pkg::PH_T1 && state_en) |=>
		(st_reg.phase == cpu_bus_pkg::PH_T2) ##1
		(st_reg.phase == cpu_bus_pkg::PH_T2 || st_reg.phase == cpu_bus_pkg::PH_T3);
	endproperty
	a_order: assert property (p_order) // R20
		else $error("T1 not followed by T2");

	property p_no_stretch;
		@(posedge MCLK) disable iff (!NRST || !SYSTEM_RESET_N)
		(st_reg.phase == cpu_bus_pkg::PH_T3 && state_en && STRETCH_N) |=>
		st_reg.phase == cpu_bus_pkg::PH_T4;
	endproperty
	a_no_stretch: assert property (p_no_stretch) else $error("T4 missed"); // R07

	property p_stretch;
		@(posedge MCLK) disable iff (!NRST || !SYSTEM_RESET_N)
		(st_reg.phase == cpu_bus_pkg::PH_T3 && state_en && !STRETCH_N &&
		st_reg.kind != cpu_bus_pkg::BS_IDLE) |=>
		st_reg.phase == cpu_bus_pkg::PH_TW1;
	endproperty
	a_stretch: assert property (p_stretch) else $error("No extension"); // R07

	property p_resample;
		@(posedge MCLK) disable iff (!NRST || !SYSTEM_RESET_N)
		(st_reg.phase == cpu_bus_pkg::PH_TW2 && state_en) |=>
		((st_reg.phase == cpu_bus_pkg::PH_T4) == $past(STRETCH_N));
	endproperty
	a_resample: assert property (p_resample) else $error("Bad resample"); // R08

	property p_internal;
		@(posedge MCLK) disable iff (!NRST || !SYSTEM_RESET_N)
		(st_reg.phase != cpu_bus_pkg::PH_IDLE &&
		st_reg.kind == cpu_bus_pkg::BS_IDLE) |->
		(READ_STROBE_N && WRITE_STROBE_N && !DATA_OE &&
		st_reg.phase != cpu_bus_pkg::PH_TW1 && ADDR == cpu_bus_pkg::DUMMY_ADDR);
	endproperty
	a_internal: assert property (p_internal) // R03 R09
		else $error("Internal cycle");

	property p_vector;
		@(posedge MCLK) disable iff (!NRST || !SYSTEM_RESET_N)
		!VECTOR_READ_STROBE_N |-> (READ_STROBE_N && !BUS_STATUS_BIT_HI &&
		BUS_STATUS_BIT_LO && ADDR == cpu_bus_pkg::DUMMY_ADDR);
	endproperty
	a_vector: assert property (p_vector) else $error("Vector strobe"); // R04 R02

	property p_write;
		@(posedge MCLK) disable iff (!NRST || !SYSTEM_RESET_N)
		$fell(WRITE_STROBE_N) |-> DATA_OE && BUS_STATUS_BIT_HI &&
		!BUS_STATUS_BIT_LO && $past(st_reg.phase) == cpu_bus_pkg::PH_T2;
	endproperty
	a_write: assert property (p_write) else $error("Write strobe timing"); // R05

	property p_read;
		@(posedge MCLK) disable iff (!NRST || !SYSTEM_RESET_N)
		(st_reg.phase == cpu_bus_pkg::PH_T2 &&
		st_reg.kind == cpu_bus_pkg::BS_READ) |->
		!READ_STROBE_N && BUS_STATUS_BIT_HI && BUS_STATUS_BIT_LO && !DATA_OE;
	endproperty
	a_read: assert property (p_read) else $error("Read strobe missing"); // R06

	property p_reset_float;
		@(posedge MCLK) disable iff (!NRST)
		!SYSTEM_RESET_N |-> !BUS_OE && !DATA_OE && st_reg.flags ==
		cpu_bus_pkg::FLAGS_RESET && st_reg.ep == cpu_bus_pkg::PAGE_RESET;
	endproperty
	a_reset_float: assert property (p_reset_float) // R13 R16 R17
		else $error("Reset");

	property p_first;
		@(posedge MCLK) disable iff (!NRST || !SYSTEM_RESET_N)
		$changed(st_reg.proc) && st_reg.proc == cpu_bus_pkg::PS_EXCEPTION |->
		st_reg.phase == cpu_bus_pkg::PH_T1 && !INTERRUPT_ACKNOWLEDGE &&
		ADDR == cpu_bus_pkg::DUMMY_ADDR ##4 INTERRUPT_ACKNOWLEDGE;
	endproperty
	a_first: assert property (p_first) else $error("First cycle"); // R14

	property p_bank;
		@(posedge MCLK) disable iff (!NRST || !SYSTEM_RESET_N)
		(st_reg.proc == cpu_bus_pkg::PS_EXCEPTION && cycle_end &&
		st_reg.rstep == 2'h2) |=> st_reg.proc == cpu_bus_pkg::PS_EXECUTE &&
		st_reg.pc[15:8] == $past(st_reg.rdata) &&
		(!EXT_MODEL || st_reg.cb == $past(st_reg.nb));
	endproperty
	a_bank: assert property (p_bank) else $error("Reset vector load"); // R15 R18

endmodule

// ===== core/cpu_bus_pkg.sv
// Constants, types and state record of the bus-cycle and reset controller
//
// Overview of operation
// R01 - Each state lasts half a CPU clock; a plain bus cycle is four states.
// R02 - Two status bits show idle, vector fetch, memory write or memory read.
// R03 - Internal cycle floats data, keeps both strobes high, drives dummy address.
// R04 - Vector fetch uses the vector strobe in T2-T3 and a dummy address.
// R05 - Write drives data T2 through T4, strobe in T3, target address held.
// R06 - Read strobes in T2-T3, latches data, target address held.
// R07 - Stretch request low at the end of T3 inserts two extension states.
// R08 - Extension pairs repeat while the request stays low, resampled in the second.
// R09 - Internal register cycles are never stretched.
// R10 - Outside logic may steer bus buffers from the status bits.
// R11 - Five processing states: reset, execute, exception, bus release, standby.
// R12 - System reset low forces the reset state at once, without the clock.
// R13 - During reset address, data and strobes float; pull-ups make them high.
// R14 - First cycle after two clock falls carries a dummy address; acknowledge next.
// R15 - Reset exception loads counter from 000000-000001 and copies pending bank.
// R16 - Reset clears the six arithmetic flags and sets both mask bits.
// R17 - Reset clears the three page registers; pending bank resets to 01.
// R18 - Bank and page registers exist only in extended address models.
// R19 - Software initialises registers that reset leaves undefined.
// R20 - States run T1, T2, T3, T4; extension states only between T3 and T4.
package cpu_bus_pkg;

	// ----------------------------------------------------------------
	// Reset values and fixed addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] NB_RESET = 8'h01;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [7:0] FLAGS_RESET = 8'hc0;
	localparam logic [23:0] RESET_VECTOR = 24'h000000;
	localparam logic [23:0] DUMMY_ADDR = 24'h000000;
	localparam logic [1:0] FALLS_BEFORE_FIRST = 2'h2;
	localparam int WB_ADR_W = 8;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses) and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_CMD_ADDR = 8'h04;
	localparam logic [7:0] OFS_CMD_DATA = 8'h08;
	localparam logic [7:0] OFS_CMD = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_FLAGS = 8'h14;
	localparam logic [7:0] OFS_PC = 8'h18;
	localparam logic [7:0] OFS_NB = 8'h1c;
	localparam logic [7:0] OFS_CB = 8'h20;
	localparam logic [7:0] OFS_EP = 8'h24;
	localparam logic [7:0] OFS_XP = 8'h28;
	localparam logic [7:0] OFS_YP = 8'h2c;
	localparam int STAT_PROC_LSB = 0;
	localparam int STAT_BUSY = 3;
	localparam int STAT_PEND = 4;
	localparam int STAT_DATA_LSB = 8;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BS_IDLE = 2'h0, BS_VECTOR = 2'h1, BS_WRITE = 2'h2, BS_READ = 2'h3
	} bus_kind_t;
	typedef enum logic [2:0] {
		PH_T1 = 3'h0, PH_T2 = 3'h1, PH_T3 = 3'h3, PH_TW1 = 3'h7,
		PH_TW2 = 3'h6, PH_T4 = 3'h2, PH_IDLE = 3'h4
	} phase_t;
	typedef enum logic [2:0] {
		PS_RESET = 3'h0, PS_EXCEPTION = 3'h1, PS_EXECUTE = 3'h3,
		PS_RELEASE = 3'h2, PS_HALT = 3'h6, PS_SLEEP = 3'h7
	} proc_t;

	// ----------------------------------------------------------------
	// Whole state of the controller
	// ----------------------------------------------------------------
	typedef struct packed {
		phase_t phase;
		bus_kind_t kind;
		proc_t proc;
		logic [1:0] rstep;
		logic [1:0] falls;
		logic clk_ph;
		logic [7:0] div;
		logic [23:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic [15:0] pc;
		logic [7:0] flags;
		logic [7:0] nb;
		logic [7:0] cb;
		logic [7:0] ep;
		logic [7:0] xp;
		logic [7:0] yp;
		logic [23:0] cmd_addr;
		logic [7:0] cmd_data;
		bus_kind_t cmd_kind;
		logic cmd_pend;
		logic [1:0] mode_req;
		logic wb_ack;
		logic [31:0] wb_dat;
		logic rd_n;
		logic wr_n;
		logic vrd_n;
		logic dat_oe;
		logic bus_oe;
		logic interrupt_acknowledge;
		bus_kind_t status;
	} state_t;

	localparam state_t ST_INIT = '{phase: PH_IDLE, kind: BS_IDLE,
		proc: PS_RESET, cmd_kind: BS_IDLE, status: BS_IDLE,
		flags: FLAGS_RESET, nb: NB_RESET, ep: PAGE_RESET, xp: PAGE_RESET,
		yp: PAGE_RESET, rd_n: 1'b1, wr_n: 1'b1, vrd_n: 1'b1, default: '0};

endpackage

// ===== test/cpu_bus_ctrl_tb.sv
// Self-checking bench of the bus-cycle and reset controller
`timescale 1ns/100ps
module cpu_bus_ctrl_tb;
	localparam logic [7:0] VEC = 8'h5a;
	logic mclk = 0, nrst = 0, srst_n = 0, cyc = 0, stb = 0, we = 0;
	logic stretch_n, doe, boe, rd_n, wr_n, vr_n, s_hi, s_lo, interrupt_acknowledge, ack;
	logic [7:0] adr = 8'h00, din, dout;
	logic [7:0] mem [16];
	logic [7:0] ofs [6] = '{8'h14, 8'h1c, 8'h24, 8'h28, 8'h2c, 8'h30};
	logic [7:0] rst [6] = '{8'hc0, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [31:0] dat = 32'h0, dq, q;
	logic [23:0] addr;
	logic [25:0] first;
	logic [3:0] pairs = 4'h0;
	logic [15:0] lfsr = 16'h8454;
	logic seen = 0, interrupt_acknowledge_seen = 0;
	int n_fail = 0, n_tests = 0, ticks = 0, rdc = 0, wrc = 0, vrc = 0;
	logic [23:0] rq [$];

	always #4 mclk = ~mclk;

	cpu_bus_ctrl uut (.MCLK(mclk), .NRST(nrst), .SYSTEM_RESET_N(srst_n),
		.STRETCH_N(stretch_n), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe),
		.ADDR(addr), .BUS_OE(boe), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
		.VECTOR_READ_STROBE_N(vr_n), .BUS_STATUS_BIT_HI(s_hi),
		.BUS_STATUS_BIT_LO(s_lo), .INTERRUPT_ACKNOWLEDGE(interrupt_acknowledge),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_DAT_I(dat), .WB_SEL_I(4'hf), .WB_DAT_O(dq), .WB_ACK_O(ack));

	ext_bus_model #(.VEC(VEC)) partner (.MCLK(mclk), .READ_STROBE_N(rd_n),
		.WRITE_STROBE_N(wr_n), .VECTOR_READ_STROBE_N(vr_n),
		.BUS_STATUS_BIT_HI(s_hi), .BUS_STATUS_BIT_LO(s_lo), .ADDR(addr),
		.DATA_OUT(dout), .DATA_OE(doe), .WAIT_PAIRS(pairs),
		.STRETCH_N(stretch_n), .DATA_IN(din));

	// Strobe counters, start-up trace and the hang guard
	always @(posedge mclk) begin
		rdc <= rdc + int'(rd_n === 1'b0);
		wrc <= wrc + int'(wr_n === 1'b0);
		vrc <= vrc + int'(vr_n === 1'b0);
		if (rd_n === 1'b0 && (rq.size() == 0 || rq[$] !== addr))
			rq.push_back(addr);
		if (boe === 1'b1 && !seen) begin
			first <= {s_hi, s_lo, addr};
			seen <= 1'b1;
		end
		if (interrupt_acknowledge === 1'b1)
			interrupt_acknowledge_seen <= 1'b1;
		ticks <= ticks + 1;
		if (ticks == 20000) begin
			n_fail++;
			conclude();
		end
	end

	// Pseudo-random step
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One classic Wishbone cycle; read data lands in q
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do
			@(posedge mclk);
		while (ack !== 1'b1);
		q = dq;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// Poll status until no bus command is busy or pending
	task automatic settle();
		do
			wb(1'b0, cpu_bus_pkg::OFS_STATUS, 32'h0);
		while (q[4:3] !== 2'b00);
	endtask

	// Release both resets and follow the start-up fetches
	task automatic boot();
		rq.delete();
		seen = 0;
		interrupt_acknowledge_seen = 0;
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		srst_n <= 1'b1;
		do
			wb(1'b0, cpu_bus_pkg::OFS_STATUS, 32'h0);
		while (q[2:0] !== 3'h3);
		chk(32'(first), 32'h0);
		chk(32'(interrupt_acknowledge_seen), 32'h1);
		chk(32'(rq.size()), 32'h2);
		chk(32'(rq[0]), 32'h0);
		chk(32'(rq[1]), 32'h1);
		wb(1'b0, cpu_bus_pkg::OFS_PC, 32'h0);
		chk(q, {16'h0, mem[1], mem[0]});
		wb(1'b0, cpu_bus_pkg::OFS_CB, 32'h0);
		chk(q, 32'h1);
		$display("start-up sequence done");
	endtask

	// One bus cycle of kind k, stretched by p extension pairs unless internal
	task automatic cmd(input logic [1:0] k, input logic [23:0] a,
		input logic [7:0] d, input int p);
		int r, w, v;
		pairs <= 4'(p);
		wb(1'b1, cpu_bus_pkg::OFS_CMD_ADDR, {8'h0, a});
		wb(1'b1, cpu_bus_pkg::OFS_CMD_DATA, {24'h0, d});
		r = rdc;
		w = wrc;
		v = vrc;
		wb(1'b1, cpu_bus_pkg::OFS_CMD, {30'h0, k});
		settle();
		chk(32'(rdc - r), 32'(k == 3 ? 2 + 2 * p : 0));
		chk(32'(wrc - w), 32'(k == 2 ? 1 + 2 * p : 0));
		chk(32'(vrc - v), 32'(k == 1 ? 2 + 2 * p : 0));
		if (k == 2)
			mem[a[3:0]] = d;
		if (k[0])
			chk(32'(q[15:8]), 32'(k == 1 ? VEC : mem[a[3:0]]));
	endtask

	// Print the counts and the verdict, then stop
	task automatic conclude();
		$display("compared %0d, wrong %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence
	initial begin
		for (int i = 0; i < 16; i++)
			mem[i] = 8'(i * 17 + 3);
		boot();
		foreach (ofs[i]) begin
			wb(1'b0, ofs[i], 32'h0);
			chk(q, {24'h0, rst[i]});
		end
		$display("reset values done");
		for (int p = 0; p < 3; p++) begin
			lfsr = nxt(lfsr);
			for (int k = 0; k < 4; k++)
				cmd(2'(k), {lfsr, lfsr[7:0]}, lfsr[15:8] ^ 8'(k), p);
		end
		$display("bus cycles done");
		// Halt, sleep and bus release, each left again by clearing the request
		for (int m = 1; m < 4; m++) begin
			wb(1'b1, cpu_bus_pkg::OFS_MODE, 32'(m));
			settle();
			chk({29'h0, q[2:0]}, m == 3 ? 32'h2 : 32'(m + 5));
			if (m == 3)
				chk(32'(boe), 32'h0);
			wb(1'b1, cpu_bus_pkg::OFS_MODE, 32'h0);
			settle();
			chk({29'h0, q[2:0]}, 32'h3);
		end
		$display("processing states done");
		lfsr = nxt(lfsr);
		wb(1'b1, cpu_bus_pkg::OFS_EP, {16'h0, lfsr});
		wb(1'b0, cpu_bus_pkg::OFS_EP, 32'h0);
		chk(q, {24'h0, lfsr[7:0]});
		pairs <= 4'h3;
		wb(1'b1, cpu_bus_pkg::OFS_CMD, 32'h3);
		repeat (4) @(posedge mclk);
		srst_n <= 1'b0;
		#1 chk(32'({boe, doe, rd_n, wr_n, vr_n}), 32'h7);
		pairs <= 4'h0;
		boot();
		wb(1'b0, cpu_bus_pkg::OFS_EP, 32'h0);
		chk(q, 32'h0);
		$display("system reset done");
		conclude();
	end
endmodule

// ===== test/ext_bus_model.sv
// Memory and wait-request model standing on the external bus
`timescale 1ns/100ps
module ext_bus_model #(
	parameter logic [7:0] VEC = 8'h5a
) (
	input wire logic MCLK,
	input wire logic READ_STROBE_N,
	input wire logic WRITE_STROBE_N,
	input wire logic VECTOR_READ_STROBE_N,
	input wire logic BUS_STATUS_BIT_HI,
	input wire logic BUS_STATUS_BIT_LO,
	input wire logic [23:0] ADDR,
	input wire logic [7:0] DATA_OUT,
	input wire logic DATA_OE,
	input wire logic [3:0] WAIT_PAIRS,
	output logic STRETCH_N,
	output logic [7:0] DATA_IN
);
	logic [7:0] mem [16];
	int cnt = 0;

	// Preset contents, mirrored by the bench
	initial begin
		DATA_IN = 8'h00;
		for (int i = 0; i < 16; i++)
			mem[i] = 8'(i * 17 + 3);
	end

	// Wait request stays low for the asked number of extension pairs
	assign STRETCH_N = !(cnt < 2 + 2 * int'(WAIT_PAIRS));

	// Data only while a strobe asks; a toggling pattern once released
	always @(posedge MCLK) begin
		cnt <= ({BUS_STATUS_BIT_HI, BUS_STATUS_BIT_LO} != 2'h0) ? cnt + 1 : 0;
		if (READ_STROBE_N === 1'b0)
			DATA_IN <= mem[ADDR[3:0]];
		else if (VECTOR_READ_STROBE_N === 1'b0)
			DATA_IN <= VEC;
		else
			DATA_IN <= ~DATA_IN;
		if (WRITE_STROBE_N === 1'b0 && DATA_OE === 1'b1)
			mem[ADDR[3:0]] <= DATA_OUT;
	end
endmodule
